// file: tb_top.sv
// Purpose: Self-checking bench for the 8-bit interval/PWM/capture timer.
// Assumes: Prescaler tap 11 (divide by one) so each mode runs quickly.
// Notes:   Capture timing is checked within a small window, since the
//          pin passes a synchroniser before the edge detector.
`timescale 1ns/1ps
module tb_top;
   import tmr0_pkg::*;
   logic       mclk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rd_v, c0;
   logic       ovf_service_ack = 1'b0;
   wire  [7:0] reg_rdata;
   wire        cap_pin, out_pin, mc_int, ovf_int, irq;
   int         err_count = 0, n_checks = 0, n, hi;

   // Free-running 25 MHz clock.
   initial forever #20 mclk = ~mclk;

   tmr0_timer i_dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .timer_capture_pin(cap_pin),
      .timer_output_pin(out_pin), .ovf_service_ack(ovf_service_ack),
      .match_capture_interrupt(mc_int), .overflow_interrupt(ovf_int),
      .irq(irq));
   tmr0_pin_model i_pins (.mclk(mclk), .timer_output_pin(out_pin),
      .timer_capture_pin(cap_pin));

   // One compare point, so every mismatch is reported the same way.
   task automatic check(input string nm, input logic [7:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Closing report, also reached when a wait runs out.
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, d);
      @(posedge mclk);
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   // Read data is only valid in the cycle after the strobe.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   function automatic logic sig(input int w);
      case (w)
         0: return mc_int;
         1: return ovf_int;
         2: return irq;
         default: return out_pin;
      endcase
   endfunction

   // Bounded wait for an output level; running out is a failure.
   task automatic wait_for(input int w, input logic lvl, input int lim);
      for (int i = 0; i < lim; i++) begin
         @(posedge mclk);
         #1;
         if (sig(w) === lvl) return;
      end
      err_count++;
      $display("MISMATCH wait %0d expected %h seen timeout", w, lvl);
      results();
   endtask

   // One full output period from the next rising level: h counts the
   // cycles spent high, cyc the whole period; both give up at 600.
   task automatic span(output int cyc, output int h);
      wait_for(3, 1'b0, 600);
      wait_for(3, 1'b1, 600);
      cyc = 0;
      h = 0;
      while (cyc < 600 && out_pin === 1'b1) begin
         h++;
         cyc++;
         @(posedge mclk);
         #1;
      end
      while (cyc < 600 && out_pin === 1'b0) begin
         cyc++;
         @(posedge mclk);
         #1;
      end
   endtask

   initial begin
      repeat (16) @(posedge mclk);
      reset <= 1'b0;
      // Reset values and an unmapped place.
      rd(TMR0_ADDR_CTRL, rd_v);
      check("ctrl", rd_v, TMR0_CTRL_RST);
      rd(TMR0_ADDR_DATA, rd_v); check("data", rd_v, TMR0_DATA_RST);
      rd(TMR0_ADDR_PORT, rd_v);
      check("port", rd_v, TMR0_PORT_RST);
      rd(TMR0_ADDR_CNT, rd_v); check("count", rd_v, 8'h00);
      wr(8'h07, 8'h5a);
      rd(8'h07, rd_v); check("unmapped", rd_v, 8'h00);
      // Interval mode: match every 0x81 ticks, output toggles each time.
      wr(TMR0_ADDR_MASK, 8'h01);
      wr(TMR0_ADDR_DATA, 8'h80);
      wr(TMR0_ADDR_CTRL, 8'hc2);
      span(n, hi);
      check("interval", hi[7:0], 8'h81);
      check("interval_lo", 8'(n - hi), 8'h81);
      wait_for(0, 1'b1, 300);
      wait_for(2, 1'b1, 4);
      wr(TMR0_ADDR_CTRL, 8'hc3);
      rd(TMR0_ADDR_CTRL, rd_v);
      check("pend_w1", rd_v[0], 1'b1);
      wr(TMR0_ADDR_CTRL, 8'hc2);
      rd(TMR0_ADDR_CTRL, rd_v);
      check("pend_w0", rd_v[0], 1'b0);
      wr(TMR0_ADDR_STAT, 8'h01);
      wait_for(2, 1'b0, 4);
      rd(TMR0_ADDR_MASK, rd_v); check("mask", rd_v, 8'h01);
      // Counter clear from the control strobe.
      repeat (40) @(posedge mclk);
      wr(TMR0_ADDR_CTRL, 8'hca);
      rd(TMR0_ADDR_CNT, rd_v);
      check("clr", rd_v < 8'h04, 1'b1);
      rd(TMR0_ADDR_CTRL, rd_v); check("clr_rd", rd_v[3], 1'b0);
      // PWM: high while data above count, one full wrap per period.
      wr(TMR0_ADDR_DATA, 8'h40);
      wr(TMR0_ADDR_CTRL, 8'hf4);
      span(n, hi);
      check("pwm_high", hi[7:0], 8'h40);
      check("pwm_low", 8'(n - hi), 8'hc0);
      span(n, hi);
      check("pwm_period", n == TMR0_PWM_PERIOD, 1'b1);
      // Capture with the pin not routed: edges are ignored.
      wr(TMR0_ADDR_CTRL, 8'hd2);
      i_pins.drive(1'b1);
      repeat (8) @(posedge mclk);
      rd(TMR0_ADDR_CTRL, rd_v);
      check("unrouted", rd_v[0], 1'b0);
      rd(TMR0_ADDR_DATA, rd_v);
      check("unrouted_d", rd_v, 8'h40);
      // Routed, rising edge copies the count.
      i_pins.drive(1'b0);
      wr(TMR0_ADDR_PORT, 8'h04);
      repeat (4) @(posedge mclk);
      rd(TMR0_ADDR_CNT, c0);
      i_pins.drive(1'b1);
      wait_for(0, 1'b1, 20);
      rd(TMR0_ADDR_DATA, rd_v);
      check("cap_rise", (rd_v - c0) <= 8'h0c, 1'b1);
      // Falling-edge mode: a rise is ignored, a fall captures.
      wr(TMR0_ADDR_CTRL, 8'he2);
      i_pins.drive(1'b0);
      wait_for(0, 1'b1, 20);
      wr(TMR0_ADDR_CTRL, 8'he2);
      i_pins.drive(1'b1);
      repeat (8) @(posedge mclk);
      rd(TMR0_ADDR_CTRL, rd_v);
      check("cap_fall", rd_v[0], 1'b0);
      // Overflow in capture mode, cleared by the service acknowledge.
      wr(TMR0_ADDR_CTRL, 8'hd4);
      wait_for(1, 1'b1, 300);
      rd(TMR0_ADDR_STAT, rd_v);
      check("st_ovf", rd_v[1], 1'b1);
      @(posedge mclk);
      ovf_service_ack <= 1'b1;
      @(posedge mclk);
      ovf_service_ack <= 1'b0;
      repeat (3) @(posedge mclk);
      check("ovf_ack", ovf_int, 1'b0);
      check("toggles", i_pins.n_toggles > 0, 1'b1);
      results();
   end
endmodule

// file: tmr0_pin_model.sv
// Purpose: Far-side source for the capture pin, listener on the output pin.
// Assumes: One system clock; the source is slow next to the timer clock.
// Notes:   The source only moves just after a rising edge, as a real
//          driver clocked off the same board clock would.
`timescale 1ns/1ps
module tmr0_pin_model (
   // Clock.
   input  wire logic mclk,
   // Timer pins.
   input  wire logic timer_output_pin,
   output logic      timer_capture_pin
);
   // Count of output level changes, for a quick sanity look by the bench.
   int   n_toggles;
   logic last_out;

   // Idle low, so a first capture needs a real rising edge.
   initial begin
      timer_capture_pin = 1'b0;
      n_toggles = 0;
      last_out = 1'b0;
   end

   // Move the capture level right after an edge, never on it.
   task automatic drive(input logic lvl);
      @(posedge mclk);
      timer_capture_pin <= lvl;
   endtask

   // Watch the output pin the way an external receiver would.
   always @(posedge mclk) begin
      last_out <= timer_output_pin;
      if (timer_output_pin !== last_out) n_toggles <= n_toggles + 1;
   end
endmodule

// file: tmr0_pkg.sv
// Purpose: Constants shared by the 8-bit interval/PWM/capture timer.
// Assumes: Byte-wide register port, one system clock.
// Notes:   Offsets are register indices on the plain register port.
package tmr0_pkg;
   // Register offsets.
   localparam logic [7:0] TMR0_ADDR_CTRL  = 8'h00;
   localparam logic [7:0] TMR0_ADDR_DATA  = 8'h01;
   localparam logic [7:0] TMR0_ADDR_CNT   = 8'h02;
   localparam logic [7:0] TMR0_ADDR_PORT  = 8'h03;
   localparam logic [7:0] TMR0_ADDR_STAT  = 8'h04;
   localparam logic [7:0] TMR0_ADDR_MASK  = 8'h05;
   // Control register fields.
   localparam int TMR0_CTRL_PRE_HI  = 7;
   localparam int TMR0_CTRL_PRE_LO  = 6;
   localparam int TMR0_CTRL_MODE_HI = 5;
   localparam int TMR0_CTRL_MODE_LO = 4;
   localparam int TMR0_CTRL_CLR     = 3;
   localparam int TMR0_CTRL_OVF_EN  = 2;
   localparam int TMR0_CTRL_MC_EN   = 1;
   localparam int TMR0_CTRL_MC_PEND = 0;
   localparam int TMR0_PORT_CAP_SEL = 2;
   // Status / mask bit positions.
   localparam int TMR0_ST_MATCH = 0;
   localparam int TMR0_ST_OVF   = 1;
   localparam int TMR0_ST_CAP   = 2;
   // Reset values.
   localparam logic [7:0] TMR0_CTRL_RST = 8'h00;
   localparam logic [7:0] TMR0_DATA_RST = 8'hff;
   localparam logic [7:0] TMR0_PORT_RST = 8'h00;
   localparam logic [7:0] TMR0_CNT_MAX  = 8'hff;
   // Prescaler tap divisors (largest is the reset choice).
   localparam int TMR0_DIV0 = 4096;
   localparam int TMR0_DIV1 = 256;
   localparam int TMR0_DIV2 = 8;
   localparam int TMR0_DIV3 = 1;
   localparam int TMR0_PWM_PERIOD = 256;
   // Operating modes.
   typedef enum logic [1:0] {
      TMR0_INTERVAL = 2'b00,
      TMR0_CAP_RISE = 2'b01,
      TMR0_CAP_FALL = 2'b10,
      TMR0_PWM      = 2'b11
   } tmr0_mode_e;
endpackage

// file: tmr0_prescaler.sv
// Purpose: Free-running divider giving one-cycle enable pulses.
// Assumes: Divisors are powers of two up to the counter width.
// Notes:   Tap change takes effect at the next pulse of the new tap.
`timescale 1ns/1ps
module tmr0_prescaler #(
   parameter int DIV_MAX = tmr0_pkg::TMR0_DIV0
) (
   // Clock and reset.
   input  wire logic       mclk,
   input  wire logic       reset,
   // Tap select and pulse out.
   input  wire logic [1:0] tap_sel,
   output logic            tick
);
   import tmr0_pkg::*;
   localparam int W = $clog2(DIV_MAX);
   // Elaboration check: the taps need a power of two at least 4096.
   if (DIV_MAX < TMR0_DIV0 || (DIV_MAX & (DIV_MAX - 1)) != 0) begin : g_bad
      $error("tmr0_prescaler: DIV_MAX must be a power of two >= 4096");
   end
   logic [W-1:0] div_cnt;
   // Free running divider; each tap fires when its low bits are all ones.
   always_ff @(posedge mclk) begin
      if (reset) div_cnt <= '0;
      else       div_cnt <= div_cnt + 1'b1;
   end
   function automatic logic tap_hit(input logic [W-1:0] c, input int div);
      logic [W-1:0] m;
      m = W'(div - 1);
      return (c & m) == m;
   endfunction
   // Registered pulse so the counter sees a clean one-cycle enable.
   always_ff @(posedge mclk) begin
      if (reset) begin
         tick <= 1'b0;
      end else begin
         unique case (tap_sel)
            2'b00: tick <= tap_hit(div_cnt, TMR0_DIV0);
            2'b01: tick <= tap_hit(div_cnt, TMR0_DIV1);
            2'b10: tick <= tap_hit(div_cnt, TMR0_DIV2);
            2'b11: tick <= 1'b1;
         endcase
      end
   end
endmodule

// file: tmr0_timer.sv
// Purpose: 8-bit timer with interval, PWM and edge capture modes.
// Assumes: Register port with read data one cycle after read strobe.
// Notes:   Status, mask and overflow acknowledge are local additions.
// Overview of operation
// [RULE1] Match when count equals reference data.
// [RULE2] Interval: match requests interrupt, clears count.
// [RULE3] Interval: output pin toggles every match.
// [RULE4] PWM: no clear on match, wraps.
// [RULE5] PWM: low when data <= count.
// [RULE6] PWM period is 256 timer clocks.
// [RULE7] Capture edge copies count into data register.
// [RULE8] Port bit routes capture pin to timer.
// [RULE9] Capture: overflow and capture interrupts raised.
// [RULE10] Reset clears control to zero.
// [RULE11] Control bit 3 write clears counter.
// [RULE12] Overflow pending clears on service acknowledge.
// [RULE13] Bit 0 pending; write zero clears.
// [RULE14] Counter steps on prescaler enable; pin synchronised.
`timescale 1ns/1ps
module tmr0_timer (
   // Clock and reset.
   input  wire logic       mclk,
   input  wire logic       reset,
   // Register port.
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   // Pins.
   input  wire logic       timer_capture_pin,
   output logic            timer_output_pin,
   // Interrupts.
   input  wire logic       ovf_service_ack,
   output logic            match_capture_interrupt,
   output logic            overflow_interrupt,
   output logic            irq
);
   import tmr0_pkg::*;

   logic [7:0] timer_control_reg;
   logic [7:1] ctrl_cfg;
   logic       mc_pend;
   logic [7:0] timer_reference_capture_data;
   logic [7:0] port_control_reg;
   logic [7:0] count;
   logic [2:0] status;
   logic [2:0] mask;
   logic       ovf_pend;
   logic       tick;
   logic       cap_s1, cap_s2, cap_prev;
   tmr0_mode_e mode;

   // Control reads back as configuration bits over the pending flag.
   assign timer_control_reg = {ctrl_cfg, mc_pend};

   assign mode = tmr0_mode_e'(timer_control_reg[TMR0_CTRL_MODE_HI:
                                                TMR0_CTRL_MODE_LO]);

   function automatic logic wr_hit(input logic [7:0] a);
      return reg_wr && reg_addr == a;
   endfunction

   tmr0_prescaler #(.DIV_MAX(TMR0_DIV0)) u_pre (
      .mclk    (mclk),
      .reset   (reset),
      .tap_sel (timer_control_reg[TMR0_CTRL_PRE_HI:TMR0_CTRL_PRE_LO]),
      .tick    (tick)                             // see [RULE14]
   );

   // Capture pin synchroniser; only cap_s2 feeds the edge detector.
   always_ff @(posedge mclk) begin
      if (reset) begin
         cap_s1   <= 1'b0;
         cap_s2   <= 1'b0;
         cap_prev <= 1'b0;
      end else begin
         cap_s1   <= timer_capture_pin;           // see [RULE14]
         cap_s2   <= cap_s1;
         cap_prev <= cap_s2;
      end
   end

   logic match, wrap, cap_edge, cap_hit, cnt_clr;
   assign match   = count == timer_reference_capture_data; // see [RULE1]
   assign wrap    = tick && count == TMR0_CNT_MAX;
   assign cap_edge = (mode == TMR0_CAP_RISE) ? (cap_s2 && !cap_prev) :
                     (mode == TMR0_CAP_FALL) ? (!cap_s2 && cap_prev) :
                     1'b0;                                // see [RULE7]
   // A deselected pin is plain port I/O and never triggers a capture.
   assign cap_hit = cap_edge &&
                    port_control_reg[TMR0_PORT_CAP_SEL];   // see [RULE8]
   // Spelled out rather than through wr_hit, so the continuous
   // assignment sees every signal that it depends on.
   assign cnt_clr = reg_wr && reg_addr == TMR0_ADDR_CTRL &&
                    reg_wdata[TMR0_CTRL_CLR];
   logic int_match;
   assign int_match = tick && match && mode == TMR0_INTERVAL;

   // Counter: steps on ticks only, clears on interval match or software.
   always_ff @(posedge mclk) begin
      if (reset || cnt_clr) begin
         count <= 8'h00;                          // see [RULE11]
      end else if (int_match) begin
         count <= 8'h00;                          // see [RULE2]
      end else if (tick) begin
         count <= count + 8'h01;                  // see [RULE4] [RULE6]
      end
   end

   // Control register; the clear bit is a strobe and reads back zero.
   always_ff @(posedge mclk) begin
      if (reset)
         ctrl_cfg <= TMR0_CTRL_RST[7:1];          // see [RULE10]
      else if (wr_hit(TMR0_ADDR_CTRL))
         ctrl_cfg <= {reg_wdata[7:4], 1'b0, reg_wdata[2:1]};
   end

   // Match/capture pending: hardware set beats a same-cycle clear.
   logic mc_event;
   assign mc_event = int_match || cap_hit;
   always_ff @(posedge mclk) begin
      if (reset)
         mc_pend <= 1'b0;
      else if (mc_event)
         mc_pend <= 1'b1;                         // see [RULE2] [RULE9]
      else if (wr_hit(TMR0_ADDR_CTRL) && !reg_wdata[TMR0_CTRL_MC_PEND])
         mc_pend <= 1'b0;                         // see [RULE13]
   end

   // Overflow pending, cleared by the service acknowledge.
   logic ovf_event;
   assign ovf_event = wrap && mode != TMR0_INTERVAL;
   always_ff @(posedge mclk) begin
      if (reset)                ovf_pend <= 1'b0;
      else if (ovf_event)       ovf_pend <= 1'b1; // see [RULE9]
      else if (ovf_service_ack) ovf_pend <= 1'b0; // see [RULE12]
   end

   // Reference data: software write, or captured count.
   always_ff @(posedge mclk) begin
      if (reset)
         timer_reference_capture_data <= TMR0_DATA_RST;
      else if (cap_hit)
         timer_reference_capture_data <= count;   // see [RULE7]
      else if (wr_hit(TMR0_ADDR_DATA))
         timer_reference_capture_data <= reg_wdata;
   end

   // Port control; only the capture select bit matters to the timer.
   always_ff @(posedge mclk) begin
      if (reset)                      port_control_reg <= TMR0_PORT_RST;
      else if (wr_hit(TMR0_ADDR_PORT)) port_control_reg <= reg_wdata;
   end

   // Sticky status, write one to clear; new events win over the clear.
   logic [2:0] ev;
   assign ev = {cap_hit, ovf_event, int_match};
   always_ff @(posedge mclk) begin
      if (reset)
         status <= 3'h0;
      else if (wr_hit(TMR0_ADDR_STAT))
         status <= (status & ~reg_wdata[2:0]) | ev;
      else
         status <= status | ev;
   end

   // Interrupt mask, same layout as the status register.
   always_ff @(posedge mclk) begin
      if (reset)                       mask <= 3'h0;
      else if (wr_hit(TMR0_ADDR_MASK)) mask <= reg_wdata[2:0];
   end

   // Output pin: toggle in interval mode, comparison in PWM mode.
   always_ff @(posedge mclk) begin
      if (reset)
         timer_output_pin <= 1'b0;
      else if (mode == TMR0_PWM)
         timer_output_pin <= timer_reference_capture_data >
                             count;               // see [RULE5]
      else if (int_match)
         timer_output_pin <= !timer_output_pin;   // see [RULE3]
   end

   // Interrupt outputs, registered from the gated pending bits.
   always_ff @(posedge mclk) begin
      if (reset) begin
         match_capture_interrupt <= 1'b0;
         overflow_interrupt      <= 1'b0;
         irq                     <= 1'b0;
      end else begin
         match_capture_interrupt <= timer_control_reg[TMR0_CTRL_MC_PEND] &&
                                    timer_control_reg[TMR0_CTRL_MC_EN];
         overflow_interrupt      <= ovf_pend &&
                                    timer_control_reg[TMR0_CTRL_OVF_EN];
         irq                     <= |(status & mask);
      end
   end

   // Read port; unmapped addresses return zero.
   always_ff @(posedge mclk) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            TMR0_ADDR_CTRL: reg_rdata <= timer_control_reg;
            TMR0_ADDR_DATA: reg_rdata <= timer_reference_capture_data;
            TMR0_ADDR_CNT:  reg_rdata <= count;
            TMR0_ADDR_PORT: reg_rdata <= port_control_reg;
            TMR0_ADDR_STAT: reg_rdata <= {5'h00, status};
            TMR0_ADDR_MASK: reg_rdata <= {5'h00, mask};
            default:        reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // Assertions share the system clock and, all but a_reset_ctrl, sleep while reset is high.
   default clocking cb_chk @(posedge mclk);
   endclocking
   default disable iff (reset);

   a_match_clears: assert property ( // see [RULE2]
      int_match && !cnt_clr |=> count == 8'h00)
      else $error("count not cleared on interval match");
   a_pin_toggles: assert property ( // see [RULE3]
      int_match |=> timer_output_pin != $past(timer_output_pin))
      else $error("output pin did not toggle");
   a_pwm_wraps: assert property ( // see [RULE4]
      mode == TMR0_PWM && wrap && !cnt_clr |=> count == 8'h00)
      else $error("PWM count did not wrap");
   a_pwm_level: assert property ( // see [RULE5]
      mode == TMR0_PWM && $past(mode) == TMR0_PWM |->
      timer_output_pin == ($past(timer_reference_capture_data) >
                           $past(count)))
      else $error("PWM level wrong");
   a_cap_loads: assert property ( // see [RULE7]
      cap_hit |=> timer_reference_capture_data == $past(count))
      else $error("capture did not load count");
   a_cap_gated: assert property ( // see [RULE8]
      !port_control_reg[TMR0_PORT_CAP_SEL] |-> !cap_hit)
      else $error("capture while pin deselected");
   a_ovf_pend: assert property ( // see [RULE9]
      ovf_event |=> ovf_pend)
      else $error("overflow pending not set");
   a_clr_bit: assert property ( // see [RULE11]
      cnt_clr |=> count == 8'h00)
      else $error("software clear failed");
   a_ack_clears: assert property ( // see [RULE12]
      ovf_service_ack && !ovf_event |=> !ovf_pend)
      else $error("overflow pending not cleared");
   a_pend_set: assert property ( // see [RULE13]
      mc_event |=> timer_control_reg[0] ##1
      match_capture_interrupt == $past(timer_control_reg[1]))
      else $error("match pending not set");
   a_tick_only: assert property ( // see [RULE14]
      !tick && !$past(cnt_clr) && !reset && !$past(reset) |=>
      $stable(count) || $past(cnt_clr))
      else $error("count moved without tick");
   a_reset_ctrl: assert property ( // see [RULE10]
      disable iff (1'b0) $past(reset) |-> timer_control_reg == 8'h00)
      else $error("control not cleared by reset");

   // The chains below are written as named sequences, so a failure
   // points at the stage of the chain that broke.
   sequence s_cap_seen;
      cap_hit;
   endsequence
   sequence s_cap_flagged;
      timer_control_reg[TMR0_CTRL_MC_PEND] && status[TMR0_ST_CAP];
   endsequence
   sequence s_ovf_seen;
      ovf_event && timer_control_reg[TMR0_CTRL_OVF_EN] &&
      !(reg_wr && reg_addr == TMR0_ADDR_CTRL);
   endsequence
   sequence s_ovf_raised;
      ovf_pend ##1 overflow_interrupt;
   endsequence

   a_cap_flags: assert property ( // see [RULE9]
      s_cap_seen |=> s_cap_flagged)
      else $error("capture did not raise its flags");
   a_ovf_raise: assert property ( // see [RULE9]
      s_ovf_seen |=> s_ovf_raised)
      else $error("overflow interrupt not raised");
   a_match_equal: assert property ( // see [RULE1]
      int_match |-> count == timer_reference_capture_data)
      else $error("interval match without equal count");
   a_pwm_step: assert property ( // see [RULE6]
      mode == TMR0_PWM && tick && !cnt_clr && !wrap |=>
      count == $past(count) + 8'h01)
      else $error("PWM count skipped a step");
   a_cap_sync: assert property ( // see [RULE14]
      cap_hit |->
      $past(timer_capture_pin, 2) != $past(timer_capture_pin, 3))
      else $error("capture without a synchronised pin edge");
   a_irq_level: assert property (
      irq == $past(|(status & mask)))
      else $error("interrupt level does not follow status");
   a_rdata_idle: assert property (
      !$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_pend_clear: assert property ( // see [RULE13]
      reg_wr && reg_addr == TMR0_ADDR_CTRL && !mc_event &&
      !reg_wdata[TMR0_CTRL_MC_PEND] |=> !timer_control_reg[0])
      else $error("pending flag not cleared by a zero write");
endmodule
